// ===== shared/pqm_defs.svh
// Offsets, field positions, reset values for the priority map and unknown-unicast block.
// Assumes byte-wide registers at byte addresses on the switch register port.
`ifndef PQM_DEFS_SVH
`define PQM_DEFS_SVH

`define PQM_OFF_PCP_LOW     8'h80
`define PQM_OFF_PCP_HIGH    8'h81
`define PQM_OFF_TWO_Q       8'h82
`define PQM_OFF_UU_FWD      8'h83

`define PQM_RST_PCP_LOW     8'h50
`define PQM_RST_PCP_HIGH    8'hFA
`define PQM_RST_TWO_Q_SEL   2'h2
`define PQM_TWO_Q_RSVD      6'h08
`define PQM_UU_RSVD         2'h2
`define PQM_RST_UU_EN       1'b0
`define PQM_RST_UU_MAP      5'h00

`define PQM_TWO_Q_SEL_MSB   7
`define PQM_TWO_Q_SEL_LSB   6
`define PQM_UU_EN_BIT       5
`define PQM_UU_MAP_MSB      4
`define PQM_PCP_MSB         15
`define PQM_PCP_LSB         13

`define PQM_SEL_ONLY3       2'h0
`define PQM_SEL_BAD         2'h1
`define PQM_SEL_UPPER2      2'h2
`define PQM_SEL_ALL_BUT0    2'h3

`endif

// ===== shared/pqm_pkg.sv
// Types shared by the priority map block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pqm_pkg;
    // Frame to classify: VLAN tag control word and optional ToS/DiffServ result
    typedef struct packed {
        logic        valid;
        logic [15:0] tci;
        logic        tos_valid;
        logic [1:0]  tos_result;
    } pqm_cls_req_t;

    // Classification answer
    typedef struct packed {
        logic       valid;
        logic [1:0] queue;
        logic       high;
    } pqm_cls_rsp_t;
endpackage : pqm_pkg
`default_nettype wire

// ===== hdl/pqm_top.sv
// Priority queue mapping, two-queue folding and unknown-unicast forwarding control.
// Assumes register port and frame requests come from logic on sys_clk.
//
// Operation
// RL1: Priority 0..7 maps to queue 0..3; queue 3 highest, 0 lowest.
// RL2: Eight 2-bit fields; 0..3 in 0x80, 4..7 in 0x81, low bits first.
// RL3: Tagged frame uses its value's mapping field as its priority.
// RL4: Two-queue mode folds result to low/high; 0 always low, 3 always high.
// RL5: Threshold 00: results 0,1,2 low, only 3 high.
// RL6: Threshold 10 (reset value): 0,1 low; 2,3 high.
// RL7: Threshold 11: only 0 low; 1,2,3 high.
// RL8: Software never writes threshold 01.
// RL9: Enable bit 1 forwards unknown unicast per map; 0 disables; resets to 0.
// RL10: Five-bit map, bit 0 is port 1; zero discards, set bits forward.
// RL11: Map 11111 broadcasts to all ports including uplink.
// RL12: Software preserves reserved bits when writing.
// RL13: Priority value is the 3-bit priority code of the VLAN tag.
`default_nettype none
`include "pqm_defs.svh"
module pqm_top #(
    parameter int NUM_PORTS = 5
) (
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_wdata,
    output var  logic [7:0]            reg_rdata,
    input  wire logic                  two_queue_mode,
    input  wire pqm_pkg::pqm_cls_req_t cls_req,
    output var  pqm_pkg::pqm_cls_rsp_t cls_rsp,
    input  wire logic                  uu_req,
    output var  logic                  uu_fwd_valid,
    output var  logic                  uu_special,
    output var  logic [NUM_PORTS-1:0]  uu_port_mask
);
    import pqm_pkg::*;

    logic [7:0]           pcp_low_q;
    logic [7:0]           pcp_high_q;
    logic [1:0]           two_q_sel_q;
    logic                 uu_en_q;
    logic [NUM_PORTS-1:0] uu_map_q;
    logic [15:0]          pcp_map;
    logic [2:0]           pcp;
    logic [1:0]           map_result;
    logic [1:0]           result;

    //--------------------------------------------------------------
    // Register writes
    //--------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pcp_low_q  <= `PQM_RST_PCP_LOW;
            pcp_high_q <= `PQM_RST_PCP_HIGH;
        end else if (reg_wr && reg_addr == `PQM_OFF_PCP_LOW) begin
            pcp_low_q <= reg_wdata; // [RL2]
        end else if (reg_wr && reg_addr == `PQM_OFF_PCP_HIGH) begin
            pcp_high_q <= reg_wdata; // [RL2]
        end
    end

    // Reserved bits are read-only, so a careless write cannot disturb them
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            two_q_sel_q <= `PQM_RST_TWO_Q_SEL; // [RL6]
        end else if (reg_wr && reg_addr == `PQM_OFF_TWO_Q) begin
            two_q_sel_q <= reg_wdata[`PQM_TWO_Q_SEL_MSB:`PQM_TWO_Q_SEL_LSB];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            uu_en_q  <= `PQM_RST_UU_EN; // [RL9]
            uu_map_q <= NUM_PORTS'(`PQM_RST_UU_MAP);
        end else if (reg_wr && reg_addr == `PQM_OFF_UU_FWD) begin
            uu_en_q  <= reg_wdata[`PQM_UU_EN_BIT];
            uu_map_q <= reg_wdata[NUM_PORTS-1:0];
        end
    end

    //--------------------------------------------------------------
    // Register reads, one cycle after the strobe
    //--------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `PQM_OFF_PCP_LOW) begin
                reg_rdata <= pcp_low_q;
            end else if (reg_addr == `PQM_OFF_PCP_HIGH) begin
                reg_rdata <= pcp_high_q;
            end else if (reg_addr == `PQM_OFF_TWO_Q) begin
                reg_rdata <= {two_q_sel_q, `PQM_TWO_Q_RSVD};
            end else if (reg_addr == `PQM_OFF_UU_FWD) begin
                reg_rdata <= {`PQM_UU_RSVD, uu_en_q, uu_map_q};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    //--------------------------------------------------------------
    // Classification
    //--------------------------------------------------------------
    function automatic logic fold_high(input logic [1:0] sel, input logic [1:0] r);
        logic h;
        h = 1'b0;
        case (sel)
            `PQM_SEL_ONLY3:    h = (r == 2'h3);  // [RL5]
            `PQM_SEL_ALL_BUT0: h = (r != 2'h0);  // [RL7]
            default:           h = r[1];         // [RL6]
        endcase
        return h;
    endfunction : fold_high

    assign pcp_map    = {pcp_high_q, pcp_low_q};
    assign pcp        = cls_req.tci[`PQM_PCP_MSB:`PQM_PCP_LSB]; // [RL13]
    assign map_result = pcp_map[{pcp, 1'b0} +: 2];              // [RL3]
    // A ToS/DiffServ result, when supplied, takes the place of the tag mapping
    assign result     = cls_req.tos_valid ? cls_req.tos_result : map_result;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cls_rsp <= '0;
        end else begin
            cls_rsp.valid <= cls_req.valid;
            cls_rsp.queue <= result;                                       // [RL1]
            cls_rsp.high  <= two_queue_mode && fold_high(two_q_sel_q, result); // [RL4]
        end
    end

    //--------------------------------------------------------------
    // Unknown-unicast forwarding
    //--------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            uu_fwd_valid <= 1'b0;
            uu_special   <= 1'b0;
            uu_port_mask <= '0;
        end else begin
            uu_fwd_valid <= uu_req;
            uu_special   <= uu_en_q;                            // [RL9]
            uu_port_mask <= uu_en_q ? uu_map_q : '0;            // [RL10] [RL11]
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    property p_queue_map; // [RL3]
        @(posedge sys_clk) disable iff (srst)
        cls_rsp.valid && !$past(cls_req.tos_valid) && !$past(srst) |->
            cls_rsp.queue == $past(pcp_map[{cls_req.tci[15:13], 1'b0} +: 2]);
    endproperty
    a_queue_map: assert property (p_queue_map) // [RL3]
        else $error("queue differs from mapping field");

    property p_pcp_field; // [RL13]
        @(posedge sys_clk) disable iff (srst)
        cls_req.valid && !cls_req.tos_valid && cls_req.tci[15:13] == 3'h7 |=>
            cls_rsp.queue == $past(pcp_high_q[7:6]);
    endproperty
    a_pcp_field: assert property (p_pcp_field) // [RL13]
        else $error("priority code not taken from tag");

    property p_low_write; // [RL2]
        @(posedge sys_clk) disable iff (srst)
        reg_wr && reg_addr == 8'h80 ##1 reg_rd && reg_addr == 8'h80 && !reg_wr |=>
            reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_low_write: assert property (p_low_write) // [RL2]
        else $error("pcp low map did not store write");

    property p_fold_ends; // [RL4]
        @(posedge sys_clk) disable iff (srst)
        two_queue_mode && cls_req.valid |=>
            ($past(result) != 2'h3 || cls_rsp.high) &&
            ($past(result) != 2'h0 || !cls_rsp.high);
    endproperty
    a_fold_ends: assert property (p_fold_ends) // [RL4]
        else $error("result 0 or 3 folded wrongly");

    property p_sel00; // [RL5]
        @(posedge sys_clk) disable iff (srst)
        two_queue_mode && two_q_sel_q == 2'h0 |=> cls_rsp.high == ($past(result) == 2'h3);
    endproperty
    a_sel00: assert property (p_sel00) // [RL5]
        else $error("threshold 00 fold wrong");

    property p_sel10; // [RL6]
        @(posedge sys_clk) disable iff (srst)
        two_queue_mode && two_q_sel_q == 2'h2 |=> cls_rsp.high == ($past(result) >= 2'h2);
    endproperty
    a_sel10: assert property (p_sel10) // [RL6]
        else $error("threshold 10 fold wrong");

    property p_sel11; // [RL7]
        @(posedge sys_clk) disable iff (srst)
        two_queue_mode && two_q_sel_q == 2'h3 |=> cls_rsp.high == ($past(result) != 2'h0);
    endproperty
    a_sel11: assert property (p_sel11) // [RL7]
        else $error("threshold 11 fold wrong");

    property p_uu_off; // [RL9]
        @(posedge sys_clk) disable iff (srst)
        !uu_en_q |=> !uu_special && uu_port_mask == '0;
    endproperty
    a_uu_off: assert property (p_uu_off) // [RL9]
        else $error("unknown unicast forwarded while disabled");

    property p_uu_map; // [RL10]
        @(posedge sys_clk) disable iff (srst)
        uu_en_q |=> uu_special && uu_port_mask == $past(uu_map_q);
    endproperty
    a_uu_map: assert property (p_uu_map) // [RL10]
        else $error("unknown unicast mask differs from map");

    property p_uu_bcast; // [RL11]
        @(posedge sys_clk) disable iff (srst)
        reg_wr && reg_addr == 8'h83 && reg_wdata[5:0] == 6'h3F ##1 !reg_wr |=>
            uu_port_mask == {NUM_PORTS{1'b1}};
    endproperty
    a_uu_bcast: assert property (p_uu_bcast) // [RL11]
        else $error("broadcast map not sent to all ports");

endmodule : pqm_top
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the priority map and unknown-unicast block.
// Assumes pqm_top, the shared header on the include path, and one 100 MHz clock.
`default_nettype none
`include "pqm_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pqm_pkg::*;
    // ------------------------------------------------------------
    // Signals and reference state
    // ------------------------------------------------------------
    logic         sys_clk        = 1'b0;
    logic         srst           = 1'b1;
    logic [7:0]   reg_addr       = 8'h00;
    logic         reg_wr         = 1'b0;
    logic         reg_rd         = 1'b0;
    logic [7:0]   reg_wdata      = 8'h00;
    logic [7:0]   reg_rdata;
    logic         two_queue_mode = 1'b0;
    pqm_cls_req_t cls_req        = '0;
    pqm_cls_rsp_t cls_rsp;
    logic         uu_req         = 1'b0;
    logic         uu_fwd_valid;
    logic         uu_special;
    logic [4:0]   uu_port_mask;
    int           err_total      = 0;
    int           comparisons    = 0;
    int           seed           = 60716;
    logic [7:0]   lo_m           = 8'h50;
    logic [7:0]   hi_m           = 8'hFA;
    logic [1:0]   sel_m          = 2'h2;
    logic         en_m           = 1'b0;
    logic [4:0]   map_m          = 5'h00;
    // Threshold 01 is never written: the device does not support it
    logic [1:0]   sel_tab [3]    = '{2'h0, 2'h2, 2'h3};

    pqm_top #(.NUM_PORTS(5)) pqm_top_i (
        .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .two_queue_mode(two_queue_mode), .cls_req(cls_req), .cls_rsp(cls_rsp),
        .uu_req(uu_req), .uu_fwd_valid(uu_fwd_valid), .uu_special(uu_special),
        .uu_port_mask(uu_port_mask)
    );

    always #5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Expectations, drivers and compares
    // ------------------------------------------------------------
    function automatic logic [1:0] exp_q(input logic [2:0] p, input logic tv,
                                         input logic [1:0] tr);
        logic [15:0] m;
        m = {hi_m, lo_m};
        return tv ? tr : m[2*p +: 2];
    endfunction : exp_q

    // Lowest result that counts as high for each supported threshold select
    function automatic logic fold(input logic [1:0] s, input logic [1:0] r);
        return r >= ((s == 2'h0) ? 2'h3 : (s == 2'h3) ? 2'h1 : 2'h2);
    endfunction : fold

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // All strobes are set together once per call, so back-to-back calls never
    // drop and raise the same strobe within one time step
    task automatic strobes(input logic w, input logic r, input logic c, input logic u);
        reg_wr = w;
        reg_rd = r;
        cls_req.valid = c;
        uu_req = u;
    endtask : strobes

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        strobes(1'b1, 1'b0, 1'b0, 1'b0);
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        strobes(1'b0, 1'b1, 1'b0, 1'b0);
        reg_addr = a;
        @(posedge sys_clk);
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic cls(input logic [2:0] p, input logic tv, input logic [1:0] tr);
        logic [15:0] t;
        logic [1:0]  q;
        logic        h;
        t = 16'($random(seed));
        t[15:13] = p;
        q = exp_q(p, tv, tr);
        strobes(1'b0, 1'b0, 1'b1, 1'b0);
        cls_req.tci = t;
        cls_req.tos_valid = tv;
        cls_req.tos_result = tr;
        two_queue_mode = 1'($random(seed));
        h = two_queue_mode & fold(sel_m, q);
        @(posedge sys_clk);
        #1;
        chk({4'h0, cls_rsp}, {5'h01, q, h});
    endtask : cls

    task automatic uu();
        strobes(1'b0, 1'b0, 1'b0, 1'b1);
        @(posedge sys_clk);
        #1;
        chk({1'b0, uu_fwd_valid, uu_special, uu_port_mask},
            {2'b01, en_m, en_m ? map_m : 5'h00});
    endtask : uu

    task automatic complete_run();
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        #1 srst = 1'b0;
        rd(8'h80, 8'h50);
        rd(8'h81, 8'hFA);
        rd(8'h82, 8'h88);
        rd(8'h83, 8'h80);
        for (int p = 0; p < 8; p++) begin
            cls(3'(p), 1'b0, 2'h0);
        end
        uu();
        // Unmapped address must neither store nor answer
        wr(8'h84, 8'hFF);
        rd(8'h84, 8'h00);
        for (int i = 0; i < 30; i++) begin
            lo_m = 8'($random(seed));
            hi_m = 8'($random(seed));
            sel_m = sel_tab[i % 3];
            en_m = (i < 3) ? 1'b1 : (i == 3) ? 1'b0 : 1'($random(seed));
            map_m = (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : (i < 4) ? 5'h1F : 5'($random(seed));
            // Each read follows its write at once, so back-to-back access is exercised
            wr(8'h80, lo_m);
            rd(8'h80, lo_m);
            wr(8'h81, hi_m);
            rd(8'h81, hi_m);
            wr(8'h82, {sel_m, 6'h08});
            rd(8'h82, {sel_m, 6'h08});
            wr(8'h83, {2'h2, en_m, map_m});
            rd(8'h83, {2'h2, en_m, map_m});
            for (int p = 0; p < 8; p++) begin
                cls(3'(p), ($random(seed) & 3) == 0, 2'($random(seed)));
            end
            uu();
        end
        strobes(1'b0, 1'b0, 1'b0, 1'b0);
        complete_run();
    end

    initial begin
        #100000;
        err_total++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        complete_run();
    end
endmodule : tb
`default_nettype wire
